// File: hw/lmpe_pkg.sv
// How it works
// - FFT off: read complex, log-magnitude, write back
// - Each result is 16-bit; magnitude and log results are unsigned
// - Inner source count is zero-based
// - Source steps by inner stride per sample
// - Outer loop count is zero-based
// - Source offset by outer stride per iteration
// - Destination steps by inner stride per result
// - Destination offset by outer stride per iteration
// - Source width 1 reads 32-bit words
// - Destination width 0 stores 16-bit words
// - Real-output select 1 writes real only
// - Trigger mode 000b starts set immediately
// - Interrupt enable raises interrupt on completion
// - Parameter sets run in sequence
// - Transform enable runs FFT of 2^size points
package lmpe_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int NSETS = 8;
  localparam int SET_W = 3;
  localparam int NFIELDS = 6;
  localparam logic [8:0] ADDR_CTRL = 9'h000;
  localparam logic [8:0] ADDR_STATUS = 9'h004;
  localparam int SET_AREA_BIT = 8;
  localparam int SET_IDX_LSB = 5;
  localparam int FIELD_LSB = 2;
  localparam logic [2:0] FLD_CFG = 3'h0;
  localparam logic [2:0] FLD_SRC_BASE = 3'h1;
  localparam logic [2:0] FLD_DST_BASE = 3'h2;
  localparam logic [2:0] FLD_COUNTS = 3'h3;
  localparam logic [2:0] FLD_SRC_STRIDES = 3'h4;
  localparam logic [2:0] FLD_DST_STRIDES = 3'h5;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CFG_XFORM = 0;
  localparam int CFG_MAG = 1;
  localparam int CFG_LOG = 2;
  localparam int CFG_SRC_WIDE = 3;
  localparam int CFG_DST_WIDE = 4;
  localparam int CFG_REAL = 5;
  localparam int CFG_TRIG_LSB = 6;
  localparam int CFG_IRQ = 9;
  localparam int CFG_SIZE_LSB = 12;
  localparam int CTRL_START = 0;
  localparam int CTRL_LAST_LSB = 4;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_DONE = 1;
  localparam int STATUS_SET_LSB = 4;
  localparam logic [2:0] TRIG_IMMEDIATE = 3'h0;
  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int FIFO_DEPTH = 16;
  localparam int RESULT_W = 16;
  localparam int LOG_FRAC_W = 10;
  localparam int FIFO_W = 2 + 32 + RESULT_W;

  typedef enum logic [3:0] {
    PH_IDLE, PH_ARM, PH_WAIT_TRIG, PH_XFORM, PH_RD_RE, PH_RD_IM,
    PH_CALC, PH_PUSH, PH_DRAIN, PH_END_SET
  } lmpe_phase_t;
  typedef enum logic [1:0] {W_IDLE, W_RE, W_IM} lmpe_wph_t;
endpackage

// File: hw/lmpe_engine.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Result FIFO
// ----------------------------------------
module lmpe_fifo #(
  parameter int W = 50,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lmpe_fifo_st_t;
  lmpe_fifo_st_t s_r, s_nxt;
  logic full, empty;

  assign full = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
  assign empty = s_r.wp == s_r.rp;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s_r.mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (in_valid && !full) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ----------------------------------------
// Log-magnitude parameter-set engine
// ----------------------------------------
module lmpe_engine #(
  parameter int NSETS = lmpe_pkg::NSETS
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [8:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TRIGGER_IN,
  output logic XFORM_REQ,
  output logic [15:0] XFORM_POINTS,
  input wire logic XFORM_DONE,
  output logic MEM_RD_REQ,
  output logic [31:0] MEM_RD_ADDR,
  input wire logic MEM_RD_VALID,
  input wire logic [31:0] MEM_RD_DATA,
  output logic MEM_WR_REQ,
  output logic [31:0] MEM_WR_ADDR,
  output logic [31:0] MEM_WR_DATA,
  output logic [3:0] MEM_WR_BE,
  input wire logic MEM_WR_READY,
  output logic HOST_IRQ
);
  localparam int FW = lmpe_pkg::FIFO_W;
  typedef struct packed {
    logic [NSETS-1:0][lmpe_pkg::NFIELDS-1:0][31:0] psets;
    logic avs_ack;
    logic [31:0] rdata;
    logic [lmpe_pkg::SET_W-1:0] last_set;
    logic done;
    lmpe_pkg::lmpe_phase_t phase;
    logic [lmpe_pkg::SET_W-1:0] set_idx;
    logic [15:0] in_idx;
    logic [15:0] out_idx;
    logic [31:0] src_outer;
    logic [31:0] src_addr;
    logic [31:0] dst_outer;
    logic [31:0] dst_addr;
    logic [31:0] rd_addr;
    logic [31:0] re;
    logic [31:0] im;
    logic [15:0] res;
    logic xreq;
    logic irq;
    lmpe_pkg::lmpe_wph_t wph;
    logic w_wide;
    logic w_real;
    logic [31:0] w_addr;
    logic [31:0] w_data;
    logic [3:0] w_be;
  } lmpe_eng_t;
  lmpe_eng_t s_r, s_nxt;

  logic [31:0] cfg, counts, sstr, dstr;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FW-1:0] fifo_in_data, fifo_out_data;
  logic acc, adv_inner, adv_outer;

  // Byte-lane placement: 16-bit results land on the half picked by addr[1]
  function automatic logic [35:0] wr_lane(input logic [31:0] addr, input logic wide,
                                          input logic [15:0] val);
    if (wide) begin
      wr_lane = {4'hF, 16'h0000, val};
    end else if (addr[1]) begin
      wr_lane = {4'hC, val, val};
    end else begin
      wr_lane = {4'h3, val, val};
    end
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    merge_be = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge_be[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // Magnitude is max + min/2, a cheap estimate accurate to about 12 percent
  function automatic logic [15:0] calc_result(input logic [31:0] re, input logic [31:0] im,
                                              input logic [31:0] c);
    logic [32:0] ar, ai, mx, mn, mag, norm;
    logic [5:0] p;
    ar = re[31] ? 33'(-{re[31], re}) : {1'b0, re};
    ai = im[31] ? 33'(-{im[31], im}) : {1'b0, im};
    mx = (ar > ai) ? ar : ai;
    mn = (ar > ai) ? ai : ar;
    mag = mx + (mn >> 1);
    p = 6'h00;
    for (int i = 0; i < 33; i++) begin
      if (mag[i]) begin
        p = 6'(i);
      end
    end
    norm = mag << (6'd32 - p);
    if (c[lmpe_pkg::CFG_LOG]) begin
      // Q6.10: integer log2 then ten bits of linear fraction
      calc_result = (mag == 33'h0_0000_0000) ? 16'h0000 :
                    {p, norm[31 -: lmpe_pkg::LOG_FRAC_W]};
    end else if (c[lmpe_pkg::CFG_MAG]) begin
      calc_result = (mag[32:16] != 17'h0_0000) ? 16'hFFFF : mag[15:0];
    end else begin
      calc_result = re[15:0];
    end
  endfunction

  assign cfg = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_CFG];
  assign counts = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_COUNTS];
  assign sstr = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_SRC_STRIDES];
  assign dstr = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_DST_STRIDES];

  assign acc = (AVS_READ || AVS_WRITE) && !s_r.avs_ack;
  assign AVS_WAITREQUEST = acc;
  assign AVS_READDATA = s_r.rdata;
  assign fifo_in_valid = s_r.phase == lmpe_pkg::PH_PUSH;
  assign fifo_in_data = {cfg[lmpe_pkg::CFG_DST_WIDE], cfg[lmpe_pkg::CFG_REAL],
                         s_r.dst_addr, s_r.res};
  assign fifo_out_ready = s_r.wph == lmpe_pkg::W_IDLE;
  assign adv_inner = fifo_in_valid && fifo_in_ready;
  assign adv_outer = adv_inner && (s_r.in_idx == counts[15:0]);
  assign XFORM_REQ = s_r.xreq;
  assign XFORM_POINTS = 16'h0001 << cfg[lmpe_pkg::CFG_SIZE_LSB +: 4];
  assign MEM_RD_REQ = (s_r.phase == lmpe_pkg::PH_RD_RE) || (s_r.phase == lmpe_pkg::PH_RD_IM);
  assign MEM_RD_ADDR = s_r.rd_addr;
  assign MEM_WR_REQ = s_r.wph != lmpe_pkg::W_IDLE;
  assign MEM_WR_ADDR = s_r.w_addr;
  assign MEM_WR_DATA = s_r.w_data;
  assign MEM_WR_BE = s_r.w_be;
  assign HOST_IRQ = s_r.irq;

  lmpe_fifo #(.W(FW), .DEPTH(lmpe_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    // ----------------------------------------
    // Register bus: one wait state per access
    // ----------------------------------------
    s_nxt.avs_ack = acc;
    if (acc && AVS_READ) begin
      s_nxt.rdata = lmpe_pkg::RST_WORD;
      if (AVS_ADDRESS == lmpe_pkg::ADDR_CTRL) begin
        s_nxt.rdata[lmpe_pkg::CTRL_LAST_LSB +: lmpe_pkg::SET_W] = s_r.last_set;
      end else if (AVS_ADDRESS == lmpe_pkg::ADDR_STATUS) begin
        s_nxt.rdata[lmpe_pkg::STATUS_BUSY] = s_r.phase != lmpe_pkg::PH_IDLE;
        s_nxt.rdata[lmpe_pkg::STATUS_DONE] = s_r.done;
        s_nxt.rdata[lmpe_pkg::STATUS_SET_LSB +: lmpe_pkg::SET_W] = s_r.set_idx;
      end else if (AVS_ADDRESS[lmpe_pkg::SET_AREA_BIT] && AVS_ADDRESS[4:2] < 3'h6) begin
        s_nxt.rdata = s_r.psets[AVS_ADDRESS[7:5]][AVS_ADDRESS[4:2]];
      end
    end
    if (s_r.avs_ack && AVS_WRITE) begin
      if (AVS_ADDRESS == lmpe_pkg::ADDR_CTRL && AVS_BYTEENABLE[0]) begin
        s_nxt.last_set = AVS_WRITEDATA[lmpe_pkg::CTRL_LAST_LSB +: lmpe_pkg::SET_W];
        if (AVS_WRITEDATA[lmpe_pkg::CTRL_START] && s_r.phase == lmpe_pkg::PH_IDLE) begin
          s_nxt.set_idx = '0;
          s_nxt.phase = lmpe_pkg::PH_ARM;
        end
      end else if (AVS_ADDRESS == lmpe_pkg::ADDR_STATUS && AVS_BYTEENABLE[0]) begin
        if (AVS_WRITEDATA[lmpe_pkg::STATUS_DONE]) begin
          s_nxt.done = 1'b0;
        end
      end else if (AVS_ADDRESS[lmpe_pkg::SET_AREA_BIT] && AVS_ADDRESS[4:2] < 3'h6) begin
        s_nxt.psets[AVS_ADDRESS[7:5]][AVS_ADDRESS[4:2]] =
          merge_be(s_r.psets[AVS_ADDRESS[7:5]][AVS_ADDRESS[4:2]], AVS_WRITEDATA,
                   AVS_BYTEENABLE);
      end
    end
    // ----------------------------------------
    // Parameter-set sequencer and reader
    // ----------------------------------------
    case (s_r.phase)
      lmpe_pkg::PH_IDLE: begin
      end
      lmpe_pkg::PH_ARM: begin
        s_nxt.src_outer = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_SRC_BASE];
        s_nxt.src_addr = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_SRC_BASE];
        s_nxt.dst_outer = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_DST_BASE];
        s_nxt.dst_addr = s_r.psets[s_r.set_idx][lmpe_pkg::FLD_DST_BASE];
        s_nxt.in_idx = 16'h0000;
        s_nxt.out_idx = 16'h0000;
        if (cfg[lmpe_pkg::CFG_TRIG_LSB +: 3] != lmpe_pkg::TRIG_IMMEDIATE) begin
          s_nxt.phase = lmpe_pkg::PH_WAIT_TRIG;
        end else if (cfg[lmpe_pkg::CFG_XFORM]) begin
          s_nxt.phase = lmpe_pkg::PH_XFORM;
        end else begin
          s_nxt.phase = lmpe_pkg::PH_RD_RE;
        end
      end
      lmpe_pkg::PH_WAIT_TRIG: begin
        if (TRIGGER_IN) begin
          s_nxt.phase = cfg[lmpe_pkg::CFG_XFORM] ? lmpe_pkg::PH_XFORM : lmpe_pkg::PH_RD_RE;
        end
      end
      lmpe_pkg::PH_XFORM: begin
        if (XFORM_DONE) begin
          s_nxt.phase = lmpe_pkg::PH_END_SET;
        end
      end
      lmpe_pkg::PH_RD_RE: begin
        if (MEM_RD_VALID) begin
          if (cfg[lmpe_pkg::CFG_SRC_WIDE]) begin
            s_nxt.re = MEM_RD_DATA;
            s_nxt.phase = lmpe_pkg::PH_RD_IM;
          end else begin
            s_nxt.re = {{16{MEM_RD_DATA[15]}}, MEM_RD_DATA[15:0]};
            s_nxt.im = {{16{MEM_RD_DATA[31]}}, MEM_RD_DATA[31:16]};
            s_nxt.phase = lmpe_pkg::PH_CALC;
          end
        end
      end
      lmpe_pkg::PH_RD_IM: begin
        if (MEM_RD_VALID) begin
          s_nxt.im = MEM_RD_DATA;
          s_nxt.phase = lmpe_pkg::PH_CALC;
        end
      end
      lmpe_pkg::PH_CALC: begin
        s_nxt.res = calc_result(s_r.re, s_r.im, cfg);
        s_nxt.phase = lmpe_pkg::PH_PUSH;
      end
      lmpe_pkg::PH_PUSH: begin
        if (adv_outer) begin
          s_nxt.in_idx = 16'h0000;
          if (s_r.out_idx == counts[31:16]) begin
            s_nxt.phase = lmpe_pkg::PH_DRAIN;
          end else begin
            s_nxt.out_idx = s_r.out_idx + 16'h0001;
            s_nxt.src_outer = s_r.src_outer + {16'h0000, sstr[31:16]};
            s_nxt.src_addr = s_r.src_outer + {16'h0000, sstr[31:16]};
            s_nxt.dst_outer = s_r.dst_outer + {16'h0000, dstr[31:16]};
            s_nxt.dst_addr = s_r.dst_outer + {16'h0000, dstr[31:16]};
            s_nxt.phase = lmpe_pkg::PH_RD_RE;
          end
        end else if (adv_inner) begin
          s_nxt.in_idx = s_r.in_idx + 16'h0001;
          s_nxt.src_addr = s_r.src_addr + {16'h0000, sstr[15:0]};
          s_nxt.dst_addr = s_r.dst_addr + {16'h0000, dstr[15:0]};
          s_nxt.phase = lmpe_pkg::PH_RD_RE;
        end
      end
      lmpe_pkg::PH_DRAIN: begin
        // Set is complete only once every result is in memory
        if (!fifo_out_valid && s_r.wph == lmpe_pkg::W_IDLE) begin
          s_nxt.phase = lmpe_pkg::PH_END_SET;
        end
      end
      lmpe_pkg::PH_END_SET: begin
        s_nxt.irq = cfg[lmpe_pkg::CFG_IRQ];
        if (s_r.set_idx == s_r.last_set) begin
          s_nxt.done = 1'b1;
          s_nxt.phase = lmpe_pkg::PH_IDLE;
        end else begin
          s_nxt.set_idx = s_r.set_idx + 3'h1;
          s_nxt.phase = lmpe_pkg::PH_ARM;
        end
      end
      default: begin
        s_nxt.phase = lmpe_pkg::PH_IDLE;
      end
    endcase
    s_nxt.xreq = s_nxt.phase == lmpe_pkg::PH_XFORM;
    s_nxt.rd_addr = (s_nxt.phase == lmpe_pkg::PH_RD_IM) ? s_nxt.src_addr + 32'h0000_0004 :
                    s_nxt.src_addr;
    // ----------------------------------------
    // Writer: drains the FIFO into local memory
    // ----------------------------------------
    case (s_r.wph)
      lmpe_pkg::W_IDLE: begin
        if (fifo_out_valid) begin
          s_nxt.w_wide = fifo_out_data[FW-1];
          s_nxt.w_real = fifo_out_data[FW-2];
          s_nxt.w_addr = fifo_out_data[47:16];
          {s_nxt.w_be, s_nxt.w_data} = wr_lane(fifo_out_data[47:16], fifo_out_data[FW-1],
                                                fifo_out_data[15:0]);
          s_nxt.wph = lmpe_pkg::W_RE;
        end
      end
      lmpe_pkg::W_RE: begin
        if (MEM_WR_READY) begin
          if (s_r.w_real) begin
            s_nxt.wph = lmpe_pkg::W_IDLE;
          end else begin
            s_nxt.w_addr = s_r.w_addr + (s_r.w_wide ? 32'h0000_0004 : 32'h0000_0002);
            {s_nxt.w_be, s_nxt.w_data} = wr_lane(s_nxt.w_addr, s_r.w_wide, 16'h0000);
            s_nxt.wph = lmpe_pkg::W_IM;
          end
        end
      end
      lmpe_pkg::W_IM: begin
        if (MEM_WR_READY) begin
          s_nxt.wph = lmpe_pkg::W_IDLE;
        end
      end
      default: begin
        s_nxt.wph = lmpe_pkg::W_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_src_inner_step: assert property (adv_inner && !adv_outer |=>
    s_r.src_addr == $past(s_r.src_addr) + {16'h0000, $past(sstr[15:0])})
    else $error("source address did not advance by inner stride");
  a_src_outer_step: assert property (adv_outer && s_r.out_idx != counts[31:16] |=>
    s_r.src_addr == $past(s_r.src_outer) + {16'h0000, $past(sstr[31:16])})
    else $error("source address did not advance by outer stride");
  a_dst_inner_step: assert property (adv_inner && !adv_outer |=>
    s_r.dst_addr - $past(s_r.dst_addr) == {16'h0000, $past(dstr[15:0])})
    else $error("destination address did not advance by inner stride");
  a_dst_outer_step: assert property (adv_outer && s_r.out_idx != counts[31:16] |=>
    s_r.dst_addr == $past(s_r.dst_outer) + {16'h0000, $past(dstr[31:16])})
    else $error("destination address did not advance by outer stride");
  a_loop_end: assert property (adv_outer && s_r.out_idx == counts[31:16] |=>
    s_r.phase == lmpe_pkg::PH_DRAIN ##1 s_r.in_idx == 16'h0000)
    else $error("loop did not end after last outer iteration");
  a_inner_bound: assert property (s_r.phase == lmpe_pkg::PH_PUSH |->
    s_r.in_idx <= counts[15:0])
    else $error("inner index passed the programmed count");
  a_word_fetch: assert property (s_r.phase == lmpe_pkg::PH_RD_RE && MEM_RD_VALID &&
    cfg[lmpe_pkg::CFG_SRC_WIDE] |=> MEM_RD_REQ && MEM_RD_ADDR == $past(MEM_RD_ADDR) + 32'h4)
    else $error("imaginary word not fetched four bytes on");
  a_half_store: assert property (MEM_WR_REQ && !s_r.w_wide |->
    MEM_WR_BE == (MEM_WR_ADDR[1] ? 4'hC : 4'h3))
    else $error("half-word store used wrong byte lanes");
  a_real_only: assert property (s_r.wph == lmpe_pkg::W_RE && s_r.w_real && MEM_WR_READY
    |=> !MEM_WR_REQ)
    else $error("imaginary part written for real output");
  a_immediate: assert property (s_r.phase == lmpe_pkg::PH_ARM &&
    cfg[lmpe_pkg::CFG_TRIG_LSB +: 3] == lmpe_pkg::TRIG_IMMEDIATE |=>
    s_r.phase != lmpe_pkg::PH_WAIT_TRIG)
    else $error("immediate set waited for a trigger");
  a_irq_cause: assert property (HOST_IRQ |->
    $past(s_r.phase) == lmpe_pkg::PH_END_SET && $past(cfg[lmpe_pkg::CFG_IRQ]))
    else $error("interrupt without enabled set completion");
  a_set_order: assert property (s_r.phase == lmpe_pkg::PH_END_SET &&
    s_r.set_idx != s_r.last_set |=> s_r.set_idx == $past(s_r.set_idx) + 3'h1)
    else $error("parameter sets ran out of order");
  a_log_range: assert property (fifo_in_valid && cfg[lmpe_pkg::CFG_LOG] |->
    fifo_in_data[15:10] <= 6'd32)
    else $error("log result exponent out of range");
  a_xform_hold: assert property (XFORM_REQ && !XFORM_DONE |=> XFORM_REQ)
    else $error("transform request dropped early");
endmodule
`default_nettype wire

// File: verif/lmpe_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Local memory stand-in
// ----------------------------------------
module lmpe_mem_model (
  input wire logic clk,
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  output logic rd_valid,
  output logic [31:0] rd_data,
  input wire logic wr_req,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_be,
  output logic wr_ready,
  input wire logic [7:0] rd_lat,
  input wire logic [7:0] wr_lat
);
  logic [31:0] mem [int];
  logic [15:0] wr_got [int];
  int wn = 0;
  logic [7:0] rc = 0;
  logic [7:0] wc = 0;
  initial begin
    rd_valid = 0;
    rd_data = 0;
    wr_ready = 0;
  end
  always @(posedge clk) begin
    if (rd_valid || !rd_req || rc < rd_lat) begin
      // Idle data toggles so a stale word never looks valid
      rd_valid <= 1'b0;
      rd_data <= ~rd_data;
      rc <= (rd_valid || !rd_req) ? 8'h00 : rc + 8'h01;
    end else begin
      rd_valid <= 1'b1;
      rd_data <= mem.exists(int'(rd_addr)) ? mem[int'(rd_addr)] : 32'h0000_0000;
    end
    if (wr_req && wr_ready) begin
      wr_got[int'(wr_addr)] = wr_be[0] ? wr_data[15:0] : wr_data[31:16];
      wn <= wn + 1;
      wr_ready <= 1'b0;
      wc <= 8'h00;
    end else if (wr_req && wc >= wr_lat) begin
      wr_ready <= 1'b1;
    end else if (wr_req) begin
      wc <= wc + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, rd = 0, wr = 0, trg = 0, xd = 0;
  logic [8:0] adr = 0;
  logic [31:0] wd = 0, rdat, mra, mrd, mwa, mwd;
  logic [3:0] be = 0, mwb;
  logic [3:0] bus_be = 4'hf;
  logic wt, xr, mrq, mrv, mwq, mwr, irq;
  logic [15:0] xp;
  logic [7:0] rl = 0, wl = 0;
  logic [31:0] seed = 32'h314f_3a75;
  int failures = 0, n_checks = 0, irq_n = 0, xf_n = 0;
  always #4 clk = ~clk;
  lmpe_engine lmpe_engine_i (.CLK_SYS(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wt), .TRIGGER_IN(trg), .XFORM_REQ(xr), .XFORM_POINTS(xp),
    .XFORM_DONE(xd), .MEM_RD_REQ(mrq), .MEM_RD_ADDR(mra), .MEM_RD_VALID(mrv),
    .MEM_RD_DATA(mrd), .MEM_WR_REQ(mwq), .MEM_WR_ADDR(mwa), .MEM_WR_DATA(mwd),
    .MEM_WR_BE(mwb), .MEM_WR_READY(mwr), .HOST_IRQ(irq));
  lmpe_mem_model lmpe_mem_model_i (.clk(clk), .rd_req(mrq), .rd_addr(mra), .rd_valid(mrv),
    .rd_data(mrd), .wr_req(mwq), .wr_addr(mwa), .wr_data(mwd), .wr_be(mwb),
    .wr_ready(mwr), .rd_lat(rl), .wr_lat(wl));
  // ----------------------------------------
  // Checking and bus helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, input int a, input logic [31:0] d, output logic [31:0] q);
    logic got;
    got = 0;
    q = 0;
    adr <= 9'(a);
    wd <= d;
    wr <= w;
    rd <= !w;
    be <= bus_be;
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk);
      got = (wt === 1'b0);
      q = rdat;
    end
    if (!got) begin
      failures++;
      report_and_stop();
    end
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic wreg(input int a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic lm_set(input int s, input logic [2:0] tm, input logic [15:0] n,
                        input logic [5:0] md, input logic [15:0] ds);
    wreg(256 + s * 32, {22'h0, 1'b1, tm, md});
    wreg(260 + s * 32, 32'h0000_0000);
    wreg(264 + s * 32, 32'h0000_8000);
    wreg(268 + s * 32, {16'h0002, n});
    wreg(272 + s * 32, 32'h1400_0008);
    wreg(276 + s * 32, {16'h0400, ds});
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int sa(input int k, input int n);
    return (k % (n + 1)) * 8 + (k / (n + 1)) * 5120;
  endfunction
  function automatic int da(input int k, input int n, input int s);
    return 32768 + (k % (n + 1)) * s + (k / (n + 1)) * 1024;
  endfunction
  function automatic logic [15:0] lm(input logic [31:0] re, input logic [31:0] im,
                                     input logic lg);
    logic [31:0] a, b, m;
    logic [47:0] f;
    int p;
    a = re[31] ? -re : re;
    b = im[31] ? -im : im;
    m = (a > b) ? a + (b >> 1) : b + (a >> 1);
    if (!lg) return (m[31:16] != 16'h0000) ? 16'hffff : m[15:0];
    if (m == 0) return 16'h0000;
    p = 0;
    for (int i = 0; i < 32; i++) if (m[i]) p = i;
    f = ({16'h0000, m} << 10) >> p;
    return {p[5:0], f[9:0]};
  endfunction
  // ----------------------------------------
  // Far-side transform engine and interrupt count
  // ----------------------------------------
  always @(posedge clk) begin
    xd <= (xr === 1'b1 && !xd);
    if (irq === 1'b1) irq_n++;
    if (xr === 1'b1 && !xd) begin
      xf_n++;
      chk(32'(xp), 32'h0000_0008);
    end
  end
  initial begin
    logic [31:0] q, w;
    int n, p;
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    wreg(280, 32'h1234_5678);
    bus(1'b0, 280, 0, q);
    chk(q, 32'h0000_0000);
    // Partial byte enables merge into the stored word
    wreg(324, 32'h1234_5678);
    bus_be = 4'h3;
    wreg(324, 32'haaaa_bbbb);
    bus_be = 4'hf;
    bus(1'b0, 324, 0, q);
    chk(q, 32'h1234_bbbb);
    for (int t = 0; t < 3; t++) begin
      // Pass 1 stalls writes long enough to fill the result queue;
      // pass 2 is 16-bit source, 32-bit complex destination, magnitude only
      n = (t == 1) ? 31 : 3;
      rl <= (t == 1) ? 8'd2 : 8'd0;
      wl <= (t == 1) ? 8'd40 : 8'd0;
      p = lmpe_mem_model_i.wn;
      lmpe_mem_model_i.wr_got.delete();
      for (int k = 0; k < 3 * (n + 1); k++) begin
        seed = lfsr(seed);
        lmpe_mem_model_i.mem[sa(k, n)] = (t == 2) ? seed : {{16{seed[15]}}, seed[15:0]};
        lmpe_mem_model_i.mem[sa(k, n) + 4] = {{16{seed[31]}}, seed[31:16]};
      end
      if (t == 0) begin
        wreg(256, 32'h0000_3001);
        lm_set(1, 3'h0, 16'(n), 6'b10_1110, 16'h0002);
        wreg(0, 32'h0000_0011);
      end else begin
        lm_set(0, (t == 1) ? 3'h3 : 3'h0, 16'(n), (t == 1) ? 6'b10_1110 : 6'b01_0010,
          (t == 1) ? 16'h0002 : 16'h0008);
        wreg(0, 32'h0000_0001);
        if (t == 1) begin
          repeat (30) @(posedge clk);
          chk(32'(lmpe_mem_model_i.wn - p), 32'h0000_0000);
          trg <= 1;
          @(posedge clk);
          trg <= 0;
        end
      end
      q = 1;
      for (int i = 0; i < 3000 && q[0]; i++) bus(1'b0, 4, 0, q);
      if (q[0]) begin
        failures++;
        report_and_stop();
      end
      chk(q & 32'h2, 32'h2);
      chk(32'(irq_n), 32'(t + 1));
      chk(32'(xf_n), 32'h0000_0001);
      chk(32'(lmpe_mem_model_i.wn - p), 32'(((t == 2) ? 6 : 3) * (n + 1)));
      for (int k = 0; k < 3 * (n + 1); k++) begin
        w = lmpe_mem_model_i.mem[sa(k, n)];
        if (t == 2) begin
          chk(32'(lmpe_mem_model_i.wr_got[da(k, n, 8)]), 32'(lm({{16{w[15]}}, w[15:0]},
            {{16{w[31]}}, w[31:16]}, 1'b0)));
          chk(32'(lmpe_mem_model_i.wr_got[da(k, n, 8) + 4]), 32'h0000_0000);
        end else begin
          chk(32'(lmpe_mem_model_i.wr_got[da(k, n, 2)]), 32'(lm(w,
            lmpe_mem_model_i.mem[sa(k, n) + 4], 1'b1)));
        end
      end
      bus(1'b0, 0, 0, q);
      chk(q, (t == 0) ? 32'h0000_0010 : 32'h0000_0000);
      wreg(4, 32'h0000_0002);
      bus(1'b0, 4, 0, q);
      chk(q & 32'h2, 32'h0);
      $display("test %0d done", t);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
